// ### testbench/phy_link_status_receive_tb.sv
`timescale 1ns/1ps
`default_nettype none

module phy_link_status_receive_tb
    import plsr_pkg::*;
;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] evt = 4'h0, regReadAddr = 4'h0, stCyc, rxOn, rxN;
    logic regReadReq = 1'h0, selfIdDone = 1'h0, rxPrefix = 1'h0;
    logic rxValid = 1'h0, rxEnd = 1'h0, stDone, rxDone;
    logic [7:0] regReadData = 8'h00, phyIdReg = 8'h00, rxData = 8'h00, rxB0, rxB1;
    logic [1:0] rxSpeed = 2'h0, lines, stPrev, stNext;
    logic [0:7] dLines, rxSpd;
    logic [0:15] stWord;
    logic [0:7] spdTab [4] = '{SPD_S100, SPD_S200, SPD_S400, SPD_INVALID};
    int errors = 0;
    int numChecks = 0;

    always #50 clk = ~clk;

    plsr_phy_link u_plsr_phy_link (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .arbResetGap(evt[0]),
        .subactionGap(evt[1]), .busResetEntry(evt[2]), .phyInterrupt(evt[3]),
        .regReadReq(regReadReq), .regReadAddr(regReadAddr),
        .regReadData(regReadData), .selfIdDone(selfIdDone), .phyIdReg(phyIdReg),
        .rxPrefix(rxPrefix), .rxSpeed(rxSpeed), .rxValid(rxValid),
        .rxData(rxData), .rxEnd(rxEnd), .interfaceStateLines(lines),
        .dataLines(dLines));

    plsr_link_model u_plsr_link_model (
        .clk(clk), .reset_n(reset_n), .interfaceStateLines(lines),
        .dataLines(dLines), .stDone(stDone), .stCyc(stCyc), .stWord(stWord),
        .stPrev(stPrev), .stNext(stNext), .rxDone(rxDone), .rxOn(rxOn),
        .rxSpd(rxSpd), .rxN(rxN), .rxB0(rxB0), .rxB1(rxB1));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        cmp(32'(n < 50), 32'h1, "apb answer");
        if (n >= 50) begin
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic waitDone(input logic isRx);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((isRx ? rxDone : stDone) !== 1'h1 && n < 300);
        if (n >= 300) begin
            $display("[ERR] %0t wait timed out", $time);
            errors++;
            print_verdict();
        end
    endtask : waitDone

    task automatic ev(input logic [3:0] f, input logic rr, input logic sid);
        @(posedge clk);
        evt <= f;
        regReadReq <= rr;
        selfIdDone <= sid;
        @(posedge clk);
        evt <= 4'h0;
        regReadReq <= 1'h0;
        selfIdDone <= 1'h0;
    endtask : ev

    task automatic rx(input logic [1:0] s, input int n);
        @(posedge clk);
        rxPrefix <= 1'h1;
        rxSpeed <= s;
        @(posedge clk);
        rxPrefix <= 1'h0;
        for (int k = 0; k < n; k++) begin
            rxValid <= 1'h1;
            rxData <= 8'hA0 + 8'(k);
            @(posedge clk);
        end
        rxValid <= 1'h0;
        rxEnd <= 1'h1;
        @(posedge clk);
        rxEnd <= 1'h0;
    endtask : rx

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        int hits;
        int n;
        repeat (4) @(posedge clk);
        reset_n <= 1'h1;
        regReadAddr <= 4'hA;
        regReadData <= 8'h5C;
        phyIdReg <= 8'h3F;
        apb(1'h0, OFF_CTRL, 32'h0);
        cmp(rd, CTRL_RESET, "ctrl reset");
        apb(1'h0, OFF_STATUS, 32'h0);
        cmp(rd, 32'h0, "status reset");
        apb(1'h0, 8'h10, 32'h0);
        cmp({31'h0, er}, 32'h1, "unmapped err");
        for (int i = 0; i < 4; i++) begin
            ev(4'h1 << i, 1'h0, 1'h0);
            waitDone(1'h0);
            cmp(32'(stCyc), 32'h2, "short length");
            cmp(32'(stWord[0:3]), 32'h8 >> i, "flag position");
            cmp(32'(stPrev), 32'(CTL_IDLE), "start from idle");
        end
        apb(1'h1, OFF_CTRL, 32'h0);
        ev(4'h8, 1'h0, 1'h0);
        hits = 0;
        repeat (12) begin
            @(negedge clk);
            hits += int'(lines === CTL_STATUS);
        end
        cmp(hits, 32'h0, "status while off");
        apb(1'h0, OFF_STATUS, 32'h0);
        cmp(rd, 32'h8, "flag pending");
        apb(1'h1, OFF_CTRL, 32'h1);
        waitDone(1'h0);
        cmp(32'(stWord[0:3]), 32'h1, "flag after enable");
        ev(4'h0, 1'h1, 1'h0);
        waitDone(1'h0);
        cmp(32'(stCyc), 32'h8, "long length");
        cmp(32'(stWord[4:15]), 32'hA5C, "addr and data");
        ev(4'h0, 1'h0, 1'h1);
        waitDone(1'h0);
        cmp(32'(stWord[4:15]), {20'h0, PHY_ID_ADDR, 8'h3F}, "self id reg");
        ev(4'h1, 1'h1, 1'h0);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (lines !== CTL_STATUS && n < 50);
        if (n >= 50) begin
            $display("[ERR] %0t status start timed out", $time);
            errors++;
            print_verdict();
        end
        rx(2'h0, 0);
        waitDone(1'h0);
        cmp(32'(stCyc), 32'h2, "cut length");
        cmp(32'(stNext), 32'(CTL_RECEIVE), "cut by receive");
        waitDone(1'h0);
        cmp(32'(stCyc), 32'h8, "retry length");
        cmp(32'(stWord), 32'h0A5C, "flags not resent");
        for (int s = 0; s < 4; s++) begin
            rx(2'(s), 2);
            waitDone(1'h1);
            cmp(32'(rxOn != 4'h0), 32'h1, "data-on first");
            cmp(32'(rxSpd), 32'(spdTab[s]), "speed code");
            cmp(32'(rxN), s < 3 ? 32'h2 : 32'h0, "byte count");
            cmp(32'({rxB0, rxB1}), 32'hA0A1, "bytes");
        end
        rx(2'h0, 0);
        waitDone(1'h1);
        cmp(32'(rxOn), 32'h1, "null data-on");
        cmp(32'(rxSpd), 32'(DATA_ON), "null no speed");
        apb(1'h0, OFF_RXCOUNT, 32'h0);
        cmp(rd, 32'h6, "packets seen");
        apb(1'h0, OFF_STCOUNT, 32'h0);
        cmp(rd, 32'h8, "transfers done");
        print_verdict();
    end
endmodule : phy_link_status_receive_tb

`default_nettype wire

// ### testbench/plsr_link_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Link side observer
// ****************************************
module plsr_link_model
    import plsr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Interface lines
    input wire logic [1:0] interfaceStateLines,
    input wire logic [0:7] dataLines,
    // Status transfer result
    output logic stDone,
    output logic [3:0] stCyc,
    output logic [0:15] stWord,
    output logic [1:0] stPrev,
    output logic [1:0] stNext,
    // Receive result
    output logic rxDone,
    output logic [3:0] rxOn,
    output logic [0:7] rxSpd,
    output logic [3:0] rxN,
    output logic [7:0] rxB0,
    output logic [7:0] rxB1
);
    logic [1:0] prevQ;
    logic spdSeenQ;
    logic spdOk;

    assign spdOk = (rxSpd[0:1] == 2'h0) || (rxSpd[0:3] == 4'h4) || (rxSpd == 8'h50);

    always_ff @(posedge clk) begin
        prevQ <= reset_n ? interfaceStateLines : CTL_IDLE;
        stDone <= 1'h0;
        if (!reset_n) begin
            stCyc <= 4'h0;
        end else if (interfaceStateLines == CTL_STATUS) begin
            if (prevQ != CTL_STATUS) begin
                stCyc <= 4'h1;
                stWord <= {dataLines[0:1], 14'h0};
                stPrev <= prevQ;
            end else begin
                stCyc <= stCyc + 4'h1;
                stWord[2 * stCyc] <= dataLines[0];
                stWord[2 * stCyc + 1] <= dataLines[1];
            end
        end else if (prevQ == CTL_STATUS) begin
            stDone <= 1'h1;
            stNext <= interfaceStateLines;
        end
    end

    // speed cycle kept out of data
    always_ff @(posedge clk) begin
        rxDone <= 1'h0;
        if (!reset_n) begin
            rxN <= 4'h0;
        end else if (interfaceStateLines == CTL_RECEIVE) begin
            if (prevQ != CTL_RECEIVE) begin
                rxOn <= {3'h0, dataLines == DATA_ON};
                spdSeenQ <= 1'h0;
                rxN <= 4'h0;
                rxSpd <= DATA_ON;
            end else if (!spdSeenQ && dataLines == DATA_ON) begin
                rxOn <= rxOn + 4'h1;
            end else if (!spdSeenQ) begin
                spdSeenQ <= 1'h1;
                rxSpd <= dataLines;
            end else if (spdOk) begin
                rxN <= rxN + 4'h1;
                if (rxN == 4'h0) rxB0 <= dataLines;
                if (rxN == 4'h1) rxB1 <= dataLines;
            end
        end else if (prevQ == CTL_RECEIVE) begin
            rxDone <= 1'h1;
        end
    end
endmodule : plsr_link_model

`default_nettype wire

// ### verilog/plsr_phy_link.sv
`timescale 1ns/1ps
`default_nettype none

module plsr_phy_link
    import plsr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status events from the bus state machines
    input wire logic arbResetGap,
    input wire logic subactionGap,
    input wire logic busResetEntry,
    input wire logic phyInterrupt,
    // Register readback requests
    input wire logic regReadReq,
    input wire logic [3:0] regReadAddr,
    input wire logic [7:0] regReadData,
    input wire logic selfIdDone,
    input wire logic [7:0] phyIdReg,
    // Received packet stream from the serial bus
    input wire logic rxPrefix,
    input wire logic [1:0] rxSpeed,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxEnd,
    // Link controller interface
    output logic [1:0] interfaceStateLines,
    output logic [0:7] dataLines
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // Speed code mapping
    function automatic logic [0:7] speedCode(input logic [1:0] spd);
        case (spd)
            2'h0: speedCode = SPD_S100;
            2'h1: speedCode = SPD_S200;
            2'h2: speedCode = SPD_S400;
            default: speedCode = SPD_INVALID;
        endcase
    endfunction : speedCode

    function automatic logic [1:0] statusPair(input logic [2:0] idx, input logic [3:0] fl,
                                              input logic [3:0] ad, input logic [7:0] dt);
        logic [0:15] word;
        word = {fl[0], fl[1], fl[2], fl[3], ad, dt};
        statusPair = {word[{idx, 1'b0}], word[{idx, 1'b1}]};
    endfunction : statusPair

    // ****************************************************************
    // State
    // ****************************************************************
    plsr_state_t state_q;
    logic [3:0] flags_q;
    logic regPend_q;
    logic [3:0] regAddr_q;
    logic [7:0] regData_q;
    logic selfIdPend_q;
    logic [2:0] stCnt_q;
    logic stLong_q;
    logic [7:0] bufByte_q;
    logic bufValid_q;
    logic endPend_q;
    logic [31:0] ctrl_q;
    logic [15:0] rxCount_q;
    logic [15:0] stCount_q;
    logic [1:0] ctlLines_q;
    logic [0:7] dLines_q;

    logic enable;
    logic anyPending;
    logic startStatus;
    logic [2:0] stLen;
    logic stDone;
    logic [1:0] pair;
    logic clearLo;
    logic clearHi;
    logic regDelivered;

    assign enable = ctrl_q[CTRL_EN_BIT];
    assign anyPending = (flags_q != 4'h0) || regPend_q;
    // Start only from idle with pending status
    assign startStatus = enable && (state_q == ST_IDLE) && anyPending && !rxPrefix;
    assign stLen = stLong_q ? 3'(STATUS_LONG_CYC - 1) : 3'(STATUS_SHORT_CYC - 1);
    assign stDone = (state_q == ST_STATUS) && (stCnt_q == stLen);
    assign pair = statusPair(startStatus ? 3'h0 : 3'(stCnt_q + 3'h1), flags_q, regAddr_q,
                             regData_q);
    // Flag pairs count as sent at the edge that drives them
    assign clearLo = startStatus;
    assign clearHi = (state_q == ST_STATUS) && !rxPrefix && !stDone && (stCnt_q == 3'h0);
    // Register delivered only when its last data pair is driven
    assign regDelivered = (state_q == ST_STATUS) && stLong_q && !rxPrefix && !stDone &&
                          (stCnt_q == 3'(STATUS_LONG_CYC - 2));

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Gap, bus reset and interrupt flags, set winning over clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_q <= 4'h0;
        end else begin
            flags_q[0] <= arbResetGap || (flags_q[0] && !clearLo);
            flags_q[1] <= subactionGap || (flags_q[1] && !clearLo);
            flags_q[2] <= busResetEntry || (flags_q[2] && !clearHi);
            flags_q[3] <= phyInterrupt || (flags_q[3] && !clearHi);
        end
    end

    // ****************************************************************
    // Register readback pending
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regPend_q <= 1'b0;
            regAddr_q <= 4'h0;
            regData_q <= 8'h00;
            selfIdPend_q <= 1'b0;
        end else begin
            // Node identifier register queued after self-ID
            if (selfIdDone) begin
                selfIdPend_q <= 1'b1;
            end
            if (regDelivered) begin
                regPend_q <= 1'b0;
            end else if (!regPend_q && (selfIdDone || selfIdPend_q)) begin
                regPend_q <= 1'b1;
                regAddr_q <= PHY_ID_ADDR;
                regData_q <= phyIdReg;
                selfIdPend_q <= 1'b0;
            end else if (!regPend_q && regReadReq) begin
                // Readback request produces a full transfer
                regPend_q <= 1'b1;
                regAddr_q <= regReadAddr;
                regData_q <= regReadData;
            end
        end
    end

    // ****************************************************************
    // Interface sequencer
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bufByte_q <= 8'h00;
            bufValid_q <= 1'b0;
        end else begin
            bufByte_q <= rxData;
            bufValid_q <= rxValid;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            ctlLines_q <= CTL_IDLE;
            dLines_q <= 8'h00;
            stCnt_q <= 3'h0;
            stLong_q <= 1'b0;
            endPend_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (rxPrefix) begin
                        state_q <= ST_RXON;
                        ctlLines_q <= CTL_RECEIVE;
                        dLines_q <= DATA_ON;
                        endPend_q <= 1'b0;
                    end else if (startStatus) begin
                        // Status code with first pair on D0 and D1
                        state_q <= ST_STATUS;
                        ctlLines_q <= CTL_STATUS;
                        dLines_q <= {pair, 6'h00};
                        stCnt_q <= 3'h0;
                        stLong_q <= regPend_q;
                    end else begin
                        ctlLines_q <= CTL_IDLE;
                        dLines_q <= 8'h00;
                    end
                end
                ST_STATUS: begin
                    if (rxPrefix) begin
                        state_q <= ST_RXON;
                        ctlLines_q <= CTL_RECEIVE;
                        dLines_q <= DATA_ON;
                        endPend_q <= 1'b0;
                    end else if (stDone) begin
                        state_q <= ST_IDLE;
                        ctlLines_q <= CTL_IDLE;
                        dLines_q <= 8'h00;
                    end else begin
                        ctlLines_q <= CTL_STATUS;
                        dLines_q <= {pair, 6'h00};
                        stCnt_q <= 3'(stCnt_q + 3'h1);
                    end
                end
                ST_RXON: begin
                    // Data-on shown for at least one cycle first
                    if (rxValid) begin
                        state_q <= ST_RXDATA;
                        dLines_q <= speedCode(rxSpeed);
                        endPend_q <= rxEnd;
                    end else if (rxEnd) begin
                        // Null packet goes straight to idle
                        state_q <= ST_IDLE;
                        ctlLines_q <= CTL_IDLE;
                        dLines_q <= 8'h00;
                    end
                end
                ST_RXDATA: begin
                    if (bufValid_q) begin
                        dLines_q <= bufByte_q;
                        endPend_q <= endPend_q || rxEnd;
                    end else if (endPend_q || rxEnd) begin
                        state_q <= ST_IDLE;
                        ctlLines_q <= CTL_IDLE;
                        dLines_q <= 8'h00;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    ctlLines_q <= CTL_IDLE;
                    dLines_q <= 8'h00;
                end
            endcase
        end
    end

    assign interfaceStateLines = ctlLines_q;
    assign dataLines = dLines_q;

    // ****************************************************************
    // Activity counters
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rxCount_q <= 16'h0000;
            stCount_q <= 16'h0000;
        end else begin
            if (rxPrefix && (state_q == ST_IDLE || state_q == ST_STATUS)) begin
                rxCount_q <= 16'(rxCount_q + 16'h0001);
            end
            if (stDone && !rxPrefix) begin
                stCount_q <= 16'(stCount_q + 16'h0001);
            end
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic apbAccess;
    logic mapped;
    logic [31:0] readMux;
    logic [31:0] prdata_q;

    assign apbAccess = psel && penable;
    assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_RXCOUNT) ||
                    (paddr == OFF_STCOUNT);
    assign pready = 1'b1;
    assign pslverr = apbAccess && !mapped;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (apbAccess && pwrite && (paddr == OFF_CTRL)) begin
            ctrl_q <= {31'h0000_0000, pwdata[CTRL_EN_BIT]};
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                OFF_CTRL: readMux = ctrl_q;
                OFF_STATUS: begin
                    readMux[STAT_FLAGS_LSB +: 4] = flags_q;
                    readMux[STAT_REGPEND_BIT] = regPend_q;
                    readMux[STAT_LINES_LSB +: 2] = ctlLines_q;
                end
                OFF_RXCOUNT: readMux = {16'h0000, rxCount_q};
                OFF_STCOUNT: readMux = {16'h0000, stCount_q};
                default: readMux = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= readMux;
        end
    end

    assign prdata = prdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [3:0] stRun_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stRun_q <= 4'h0;
        end else if (ctlLines_q == CTL_STATUS) begin
            stRun_q <= 4'(stRun_q + 4'h1);
        end else begin
            stRun_q <= 4'h0;
        end
    end

    a_status_start_idle: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(ctlLines_q == CTL_STATUS) |-> $past(ctlLines_q) == CTL_IDLE && $past(anyPending))
        else $error("status transfer began without idle or pending status");
    a_status_short_len: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(ctlLines_q == CTL_STATUS) && !stLong_q |=>
        (ctlLines_q != CTL_IDLE) ##1 (ctlLines_q != CTL_STATUS))
        else $error("flag-only status transfer not two cycles");
    // Long transfer never exceeds eight cycles
    a_status_max_len: assert property (@(posedge clk) disable iff (!reset_n)
        stRun_q <= 4'(STATUS_LONG_CYC))
        else $error("status transfer longer than eight cycles");
    // Status cut only by a packet
    a_status_cut: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(ctlLines_q == CTL_STATUS) && ctlLines_q == CTL_IDLE |->
        stRun_q == 4'(STATUS_SHORT_CYC) || stRun_q == 4'(STATUS_LONG_CYC))
        else $error("status transfer ended early without receive");
    a_rx_dataon: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(ctlLines_q == CTL_RECEIVE) |-> dLines_q == DATA_ON)
        else $error("receive did not open with data-on");
    a_rx_forward: assert property (@(posedge clk) disable iff (!reset_n)
        rxPrefix && state_q != ST_RXON && state_q != ST_RXDATA |=>
        ctlLines_q == CTL_RECEIVE)
        else $error("received packet not forwarded");
    a_rx_end_idle: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(ctlLines_q == CTL_RECEIVE) |-> ctlLines_q == CTL_IDLE)
        else $error("receive did not end with idle");
    a_rx_null: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_RXON && rxEnd && !rxValid |=>
        ctlLines_q == CTL_IDLE && $past(dLines_q) == DATA_ON)
        else $error("null packet not ended after data-on");
    // Register cleared only after full readback
    a_reg_deliver: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(regPend_q) |-> $past(state_q) == ST_STATUS && $past(stCnt_q) == 3'h6)
        else $error("register readback cleared before all bits driven");
    a_selfid_reg: assert property (@(posedge clk) disable iff (!reset_n)
        selfIdDone && !regPend_q |=> regPend_q && regAddr_q == PHY_ID_ADDR)
        else $error("self-ID did not queue node identifier");

    c_long_status: cover property (@(posedge clk) disable iff (!reset_n)
        stRun_q == 4'(STATUS_LONG_CYC));
    c_status_cut: cover property (@(posedge clk) disable iff (!reset_n)
        ctlLines_q == CTL_STATUS ##1 ctlLines_q == CTL_RECEIVE);
    c_null_packet: cover property (@(posedge clk) disable iff (!reset_n)
        ctlLines_q == CTL_RECEIVE && dLines_q == DATA_ON ##1 ctlLines_q == CTL_IDLE);
    c_data_packet: cover property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_RXDATA ##1 state_q == ST_IDLE);

endmodule : plsr_phy_link

`default_nettype wire

// ### verilog/plsr_pkg.sv
`default_nettype none

package plsr_pkg;

    // Interface state line codes
    localparam logic [1:0] CTL_IDLE = 2'h0;
    localparam logic [1:0] CTL_STATUS = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;
    localparam logic [1:0] CTL_HOLD = 2'h3;

    // Data line codes during receive, D0 is bit index 0
    localparam logic [0:7] SPD_S100 = 8'h00;
    localparam logic [0:7] SPD_S200 = 8'h40;
    localparam logic [0:7] SPD_S400 = 8'h50;
    localparam logic [0:7] SPD_INVALID = 8'h60;
    localparam logic [0:7] DATA_ON = 8'hFF;

    // Status transfer lengths in clock cycles
    localparam int STATUS_SHORT_CYC = 2;
    localparam int STATUS_LONG_CYC = 8;

    // Address of the register holding the node identifier
    localparam logic [3:0] PHY_ID_ADDR = 4'h0;

    // APB register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RXCOUNT = 8'h08;
    localparam logic [7:0] OFF_STCOUNT = 8'h0C;

    // Control register fields and reset value
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // Status register fields
    localparam int STAT_FLAGS_LSB = 0;
    localparam int STAT_REGPEND_BIT = 4;
    localparam int STAT_LINES_LSB = 5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STATUS,
        ST_RXON,
        ST_RXDATA
    } plsr_state_t;

endpackage : plsr_pkg

`default_nettype wire
